// File: rtl/bal_pkg.sv
// constants, operation codes and register map of the byte arithmetic/logic datapath
// assumes a single core clock and an apb master reaching the registers
//
// What this block does
// - sum and sum-with-carry, one cycle, five flags
// - wide pair sum with constant, two cycles
// - register and constant difference, one cycle
// - register difference minus carry, one cycle
// - constant difference minus carry, one cycle
// - wide pair difference with constant, two cycles
// - conjunction touches only zero, negative, overflow
// - disjunctions touch only zero, negative, overflow
// - mask set equals disjunction with constant
// - mask clear conjoins with all-ones minus constant
// - flagged bits clear on write of one
// - io bit ops rewrite whole register
// - io bit ops reach addresses 0x00-0x1F only
package bal_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int          APB_AW       = 12;
	localparam logic [11:0] OFS_CMD      = 12'h000;
	localparam logic [11:0] OFS_DEST     = 12'h004;
	localparam logic [11:0] OFS_SRC      = 12'h008;
	localparam logic [11:0] OFS_HIGH     = 12'h00C;
	localparam logic [11:0] OFS_FLAGS    = 12'h010;
	localparam logic [11:0] OFS_STATUS   = 12'h014;
	localparam logic [11:0] OFS_IO_SEL   = 12'h018;
	localparam logic [11:0] OFS_IO_DATA  = 12'h01C;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int          FLG_C        = 0;
	localparam int          FLG_Z        = 1;
	localparam int          FLG_N        = 2;
	localparam int          FLG_V        = 3;
	localparam int          FLG_S        = 4;
	localparam int          FLG_H        = 5;
	localparam int          ST_BUSY      = 0;
	localparam int          ST_RANGE_ERR = 1;
	localparam int          IOS_BIT_LSB  = 8;
	localparam logic [7:0]  FLAGS_RST    = 8'h00;
	localparam logic [7:0]  BYTE_RST     = 8'h00;
	localparam logic [7:0]  ALL_ONES     = 8'hFF;
	localparam logic [5:0]  IO_BIT_MAX   = 6'h1F;
	localparam logic [4:0]  IO_FLAG_ADDR = 5'h0E;
	localparam logic [7:0]  IO_W1C_MASK  = 8'hC0;

	// ****************************************
	// operation codes and sequencer states
	// ****************************************
	typedef enum logic [4:0] {
		OP_SUM            = 5'h00,
		OP_SUM_CARRY      = 5'h01,
		OP_WIDE_SUM_IMM   = 5'h02,
		OP_DIFF_PAIR      = 5'h03,
		OP_DIFF_IMM       = 5'h04,
		OP_DIFF_BORROW    = 5'h05,
		OP_DIFF_BORROW_IM = 5'h06,
		OP_WIDE_DIFF_IMM  = 5'h07,
		OP_CONJ_PAIR      = 5'h08,
		OP_CONJ_IMM       = 5'h09,
		OP_DISJ_PAIR      = 5'h0A,
		OP_DISJ_IMM       = 5'h0B,
		OP_EXCL_PAIR      = 5'h0C,
		OP_MASK_SET       = 5'h0D,
		OP_MASK_CLEAR     = 5'h0E,
		OP_IO_BIT_SET     = 5'h0F,
		OP_IO_BIT_CLEAR   = 5'h10
	} bal_op_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_WIDE_HI
	} bal_state_type;

endpackage

// File: rtl/bal_core.sv
// byte arithmetic/logic datapath with apb register access and a small io space
// assumes apb master on sys_clk; io_event is synchronous to sys_clk
module bal_core #(
	parameter int IO_DEPTH = 32
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rstn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [bal_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output wire logic [31:0]                prdata,
	output wire logic                       pready,
	output wire logic                       pslverr,
	input  wire logic [7:0]                 io_event,
	output wire logic                       busy
);
	import bal_pkg::*;

	// ****************************************
	// helper functions
	// ****************************************

	// byte sum or difference, returns {carry, half, overflow, result}
	function automatic logic [10:0] arith8(input logic [7:0] a, input logic [7:0] b,
	                                       input logic cin, input logic sub);
		logic [8:0] s;
		logic       h;
		logic       v;
		s = sub ? (9'({1'b0, a}) - 9'({1'b0, b}) - 9'(cin)) : (9'(a) + 9'(b) + 9'(cin));
		if (sub) begin
			h = (~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]);
			v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
		end else begin
			h = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
			v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
		end
		return {s[8], h, v, s[7:0]};
	endfunction

	// store into an io register: flagged bits clear on one, others take the value
	function automatic logic [7:0] io_store(input logic [7:0] old, input logic [7:0] val,
	                                        input logic [7:0] w1c);
		return (val & ~w1c) | (old & w1c & ~val);
	endfunction

	// ****************************************
	// state and registers
	// ****************************************
	bal_state_type   state_q;
	bal_state_type   state_d;
	bal_op_type      op_q;
	logic [7:0]      dest_q;
	logic [7:0]      src_q;
	logic [7:0]      high_q;
	logic [7:0]      flags_q;
	logic [10:0]     io_sel_q;
	logic            wcarry_q;
	logic            range_err_q;
	logic            busy_q;
	logic            pready_q;
	logic            pslverr_q;
	logic [31:0]     prdata_q;
	logic [7:0]      io_mem_q [IO_DEPTH];

	logic            access;
	logic            wr_en;
	logic            wr_idle;
	logic            addr_ok;
	logic [10:0]     alu_arith;
	logic [7:0]      alu_res;
	logic [7:0]      alu_flags;
	logic            alu_wr;
	logic [8:0]      hi_sum;
	logic [15:0]     wide_res;
	logic [7:0]      wide_flags;
	logic [4:0]      io_addr;
	logic [7:0]      io_bitmask;
	logic [7:0]      io_old;
	logic            io_op;
	logic            io_in_range;
	logic            io_wr_en;
	logic [4:0]      io_wr_addr;
	logic [7:0]      io_wr_val;
	logic [7:0]      io_flag_next;

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign busy    = busy_q;

	// ****************************************
	// apb slave
	// ****************************************

	// write lands at the edge that samples pready high
	assign access  = psel & penable;
	assign wr_en   = access & pready_q & pwrite;
	assign wr_idle = wr_en & (state_q == ST_IDLE);
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= OFS_IO_DATA);

	// one wait state, then answer with data and error
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= access & ~pready_q;
			pslverr_q <= access & ~pready_q & ~addr_ok;
			if (access && !pready_q && !pwrite) begin
				case (paddr)
					OFS_CMD:     prdata_q <= {27'h0000000, op_q};
					OFS_DEST:    prdata_q <= {24'h000000, dest_q};
					OFS_SRC:     prdata_q <= {24'h000000, src_q};
					OFS_HIGH:    prdata_q <= {24'h000000, high_q};
					OFS_FLAGS:   prdata_q <= {24'h000000, flags_q};
					OFS_STATUS:  prdata_q <= {30'h00000000, range_err_q, busy_q};
					OFS_IO_SEL:  prdata_q <= {21'h000000, io_sel_q};
					OFS_IO_DATA: prdata_q <= {24'h000000, io_old};
					default:     prdata_q <= 32'h00000000;
				endcase
			end else begin
				prdata_q <= 32'h00000000;
			end
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (wr_idle && paddr == OFS_CMD) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (op_q == OP_WIDE_SUM_IMM || op_q == OP_WIDE_DIFF_IMM) begin
					state_d = ST_WIDE_HI;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_WIDE_HI: state_d = ST_IDLE;
			default:    state_d = ST_IDLE;
		endcase
	end

	// state, busy and latched operation
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			busy_q  <= 1'b0;
			op_q    <= OP_SUM;
		end else begin
			state_q <= state_d;
			busy_q  <= (state_d != ST_IDLE);
			if (wr_idle && paddr == OFS_CMD) begin
				op_q <= bal_op_type'(pwdata[4:0]);
			end
		end
	end

	// ****************************************
	// byte datapath
	// ****************************************
	always_comb begin
		alu_arith = 11'h000;
		alu_res   = dest_q;
		alu_flags = flags_q;
		alu_wr    = 1'b1;
		case (op_q)
			OP_SUM:            alu_arith = arith8(dest_q, src_q, 1'b0, 1'b0);
			OP_SUM_CARRY:      alu_arith = arith8(dest_q, src_q, flags_q[FLG_C], 1'b0);
			OP_DIFF_PAIR,
			OP_DIFF_IMM:       alu_arith = arith8(dest_q, src_q, 1'b0, 1'b1);
			OP_DIFF_BORROW:    alu_arith = arith8(dest_q, src_q, flags_q[FLG_C], 1'b1);
			OP_DIFF_BORROW_IM: alu_arith = arith8(dest_q, src_q, flags_q[FLG_C], 1'b1);
			OP_WIDE_SUM_IMM:   alu_arith = arith8(dest_q, src_q, 1'b0, 1'b0);
			OP_WIDE_DIFF_IMM:  alu_arith = arith8(dest_q, src_q, 1'b0, 1'b1);
			OP_CONJ_PAIR,
			OP_CONJ_IMM:       alu_res = dest_q & src_q;
			OP_DISJ_PAIR,
			OP_DISJ_IMM:       alu_res = dest_q | src_q;
			OP_EXCL_PAIR:      alu_res = dest_q ^ src_q;
			OP_MASK_SET:       alu_res = dest_q | src_q;
			OP_MASK_CLEAR:     alu_res = dest_q & (ALL_ONES - src_q);
			default:           alu_wr = 1'b0;
		endcase
		if (op_q <= OP_WIDE_DIFF_IMM) begin
			// arithmetic: carry, half, overflow, negative, zero; sign untouched
			alu_res          = alu_arith[7:0];
			alu_flags[FLG_C] = alu_arith[10];
			alu_flags[FLG_H] = alu_arith[9];
			alu_flags[FLG_V] = alu_arith[8];
			alu_flags[FLG_N] = alu_arith[7];
			alu_flags[FLG_Z] = (alu_arith[7:0] == 8'h00);
		end else if (alu_wr) begin
			// logic: overflow cleared, carry and half kept
			alu_flags[FLG_V] = 1'b0;
			alu_flags[FLG_N] = alu_res[7];
			alu_flags[FLG_Z] = (alu_res == 8'h00);
		end
	end

	// second step of the wide ops: high byte takes the low-byte carry
	assign hi_sum   = (op_q == OP_WIDE_DIFF_IMM) ? (9'(high_q) - 9'(wcarry_q)) : (9'(high_q) + 9'(wcarry_q));
	assign wide_res = {hi_sum[7:0], dest_q};

	always_comb begin
		wide_flags        = flags_q;
		wide_flags[FLG_Z] = (wide_res == 16'h0000);
		wide_flags[FLG_N] = wide_res[15];
		if (op_q == OP_WIDE_DIFF_IMM) begin
			wide_flags[FLG_V] = high_q[7] & ~wide_res[15];
			wide_flags[FLG_C] = wide_res[15] & ~high_q[7];
		end else begin
			wide_flags[FLG_V] = ~high_q[7] & wide_res[15];
			wide_flags[FLG_C] = ~wide_res[15] & high_q[7];
		end
		wide_flags[FLG_S] = wide_flags[FLG_N] ^ wide_flags[FLG_V];
	end

	// destination byte
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dest_q <= BYTE_RST;
		end else if (state_q == ST_EXEC && alu_wr) begin
			dest_q <= alu_res;
		end else if (wr_idle && paddr == OFS_DEST) begin
			dest_q <= pwdata[7:0];
		end
	end

	// high byte of a wide pair
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			high_q <= BYTE_RST;
		end else if (state_q == ST_WIDE_HI) begin
			high_q <= hi_sum[7:0];
		end else if (wr_idle && paddr == OFS_HIGH) begin
			high_q <= pwdata[7:0];
		end
	end

	// low-byte carry kept between the two wide steps
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wcarry_q <= 1'b0;
		end else if (state_q == ST_EXEC) begin
			wcarry_q <= alu_arith[10];
		end
	end

	// status flags
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= FLAGS_RST;
		end else if (state_q == ST_WIDE_HI) begin
			flags_q <= wide_flags;
		end else if (state_q == ST_EXEC && alu_wr && op_q != OP_WIDE_SUM_IMM && op_q != OP_WIDE_DIFF_IMM) begin
			flags_q <= alu_flags;
		end else if (wr_idle && paddr == OFS_FLAGS) begin
			flags_q <= pwdata[7:0];
		end
	end

	// source byte and io selector
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			src_q    <= BYTE_RST;
			io_sel_q <= 11'h000;
		end else begin
			if (wr_idle && paddr == OFS_SRC) begin
				src_q <= pwdata[7:0];
			end
			if (wr_idle && paddr == OFS_IO_SEL) begin
				io_sel_q <= pwdata[10:0];
			end
		end
	end

	// ****************************************
	// io space and bit instructions
	// ****************************************
	assign io_addr     = io_sel_q[4:0];
	assign io_bitmask  = 8'(8'h01 << io_sel_q[IOS_BIT_LSB +: 3]);
	assign io_old      = io_sel_q[5] ? 8'h00 : io_mem_q[io_addr];
	assign io_op       = (state_q == ST_EXEC) && (op_q == OP_IO_BIT_SET || op_q == OP_IO_BIT_CLEAR);
	assign io_in_range = (io_sel_q[5:0] <= IO_BIT_MAX);

	// whole-register rewrite of the old value with one bit changed
	always_comb begin
		io_wr_en   = 1'b0;
		io_wr_addr = io_addr;
		io_wr_val  = io_old;
		if (io_op && io_in_range) begin
			io_wr_en  = 1'b1;
			io_wr_val = (op_q == OP_IO_BIT_SET) ? (io_old | io_bitmask) : (io_old & ~io_bitmask);
		end else if (wr_idle && paddr == OFS_IO_DATA && !io_sel_q[5]) begin
			io_wr_en  = 1'b1;
			io_wr_val = pwdata[7:0];
		end
	end

	// next value of the flagged io register; events are or-ed in after any clear
	assign io_flag_next = ((io_wr_en && io_wr_addr == IO_FLAG_ADDR)
	                    ? io_store(io_mem_q[IO_FLAG_ADDR], io_wr_val, IO_W1C_MASK)
	                    : io_mem_q[IO_FLAG_ADDR]) | io_event;

	// io registers; a hardware event wins over a same-cycle clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < IO_DEPTH; i++) begin
				io_mem_q[i] <= BYTE_RST;
			end
		end else begin
			for (int i = 0; i < IO_DEPTH; i++) begin
				if (io_wr_en && io_wr_addr == 5'(i)) begin
					io_mem_q[i] <= io_store(io_mem_q[i], io_wr_val,
					                        (5'(i) == IO_FLAG_ADDR) ? IO_W1C_MASK : 8'h00);
				end
				if (5'(i) == IO_FLAG_ADDR) begin
					io_mem_q[i][7:6] <= io_flag_next[7:6];
				end
			end
		end
	end

	// sticky out-of-range error, cleared by writing one
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			range_err_q <= 1'b0;
		end else if (io_op && !io_in_range) begin
			range_err_q <= 1'b1;
		end else if (wr_idle && paddr == OFS_STATUS && pwdata[ST_RANGE_ERR]) begin
			range_err_q <= 1'b0;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	sequence s_wide_start;
		state_q == ST_EXEC && (op_q == OP_WIDE_SUM_IMM || op_q == OP_WIDE_DIFF_IMM);
	endsequence

	sequence s_wide_finish;
		state_q == ST_WIDE_HI ##1 state_q == ST_IDLE && !busy_q;
	endsequence

	a_sum_result: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == ST_EXEC && op_q == OP_SUM_CARRY |=>
		dest_q == 8'($past(dest_q) + $past(src_q) + 8'($past(flags_q[FLG_C]))) && state_q == ST_IDLE)
		else $error("sum with carry wrong or late");

	a_wide_two_cycles: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_wide_start |=> s_wide_finish)
		else $error("wide op not done in two cycles");

	a_diff_result: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == ST_EXEC && op_q == OP_DIFF_IMM |=>
		dest_q == 8'($past(dest_q) - $past(src_q)) && flags_q[FLG_C] == ($past(src_q) > $past(dest_q)))
		else $error("difference or borrow wrong");

	a_borrow_diff: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == ST_EXEC && (op_q == OP_DIFF_BORROW || op_q == OP_DIFF_BORROW_IM) |=>
		dest_q == 8'($past(dest_q) - $past(src_q) - 8'($past(flags_q[FLG_C]))))
		else $error("borrow-aware difference wrong");

	a_wide_diff_value: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == ST_EXEC && op_q == OP_WIDE_DIFF_IMM |=> ##1
		{high_q, dest_q} == 16'({$past(high_q, 2), $past(dest_q, 2)} - 16'($past(src_q, 2))))
		else $error("wide difference wrong");

	a_logic_keeps_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == ST_EXEC && op_q >= OP_CONJ_PAIR && op_q <= OP_MASK_CLEAR |=>
		flags_q[FLG_C] == $past(flags_q[FLG_C]) && flags_q[FLG_H] == $past(flags_q[FLG_H]) && !flags_q[FLG_V])
		else $error("logic op touched wrong flags");

	a_mask_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == ST_EXEC && op_q == OP_MASK_CLEAR |=> (dest_q & $past(src_q)) == 8'h00)
		else $error("mask clear left bits set");

	a_rmw_clears_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
		io_op && io_in_range && io_addr == IO_FLAG_ADDR && io_event == 8'h00 |=>
		(io_mem_q[IO_FLAG_ADDR] & IO_W1C_MASK & ~$past(io_bitmask)) == 8'h00)
		else $error("rewrite left a flag set");

	a_io_range_refused: assert property (@(posedge sys_clk) disable iff (!rstn)
		io_op && !io_in_range |=> range_err_q && io_mem_q[IO_FLAG_ADDR] == ($past(io_mem_q[IO_FLAG_ADDR]) | $past(io_event)))
		else $error("out-of-range bit op not refused");

	a_zero_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
		state_q == ST_EXEC && op_q <= OP_DISJ_IMM && op_q != OP_WIDE_SUM_IMM && op_q != OP_WIDE_DIFF_IMM |=>
		flags_q[FLG_Z] == (dest_q == 8'h00) && flags_q[FLG_N] == dest_q[7])
		else $error("zero or negative flag wrong");

endmodule

// File: verif/bal_evt_model.sv
// partner model: peripheral hardware raising the io status flags
// assumes the bench pulses fire on sys_clk; events land on bits 7:6
module bal_evt_model (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       fire,
	output logic      [7:0] io_event
);
	timeunit 1ns;
	timeprecision 1ps;

	// one-cycle event pulse on both flag bits, quiet otherwise
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			io_event <= 8'h00;
		end else begin
			io_event <= fire ? 8'hC0 : 8'h00;
		end
	end
endmodule

// File: verif/tb_byte_alu_arith_logic.sv
// testbench: operation table, io flag handling and apb errors
// assumes bal_pkg, bal_core and bal_evt_model are compiled first
module tb_byte_alu_arith_logic;
	timeunit 1ns;
	timeprecision 1ps;
	import bal_pkg::*;

	typedef struct packed {
		logic [4:0] op;
		logic [7:0] d;
		logic [7:0] s;
		logic [7:0] hi;
		logic [7:0] fin;
		logic [7:0] ed;
		logic [7:0] eh;
		logic [7:0] ef;
		logic [1:0] cyc;
	} bal_row_type;

	logic        sys_clk;
	logic        rstn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  io_event;
	logic        busy;
	logic        evt_fire;
	logic [31:0] rd;
	logic        er;
	int          err_count;
	int          samples_checked;

	// ****************************************
	// operation table: inputs, then result, high byte, flags, cycles
	// ****************************************
	bal_row_type rows [16] = '{
		'{OP_SUM,            8'h0F, 8'h01, 8'h00, 8'h00, 8'h10, 8'h00, 8'h20, 2'h1},
		'{OP_SUM_CARRY,      8'h7F, 8'h00, 8'h00, 8'h01, 8'h80, 8'h00, 8'h2C, 2'h1},
		'{OP_WIDE_SUM_IMM,   8'hFF, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 2'h2},
		'{OP_DIFF_PAIR,      8'h10, 8'h01, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h20, 2'h1},
		'{OP_DIFF_IMM,       8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h25, 2'h1},
		'{OP_DIFF_BORROW,    8'h80, 8'h00, 8'h00, 8'h01, 8'h7F, 8'h00, 8'h28, 2'h1},
		'{OP_DIFF_BORROW_IM, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 2'h1},
		'{OP_WIDE_DIFF_IMM,  8'h00, 8'h01, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h15, 2'h2},
		'{OP_CONJ_PAIR,      8'hF0, 8'h8F, 8'h00, 8'h39, 8'h80, 8'h00, 8'h35, 2'h1},
		'{OP_CONJ_IMM,       8'h0F, 8'hF0, 8'h00, 8'h0C, 8'h00, 8'h00, 8'h02, 2'h1},
		'{OP_DISJ_PAIR,      8'h01, 8'h80, 8'h00, 8'h02, 8'h81, 8'h00, 8'h04, 2'h1},
		'{OP_DISJ_IMM,       8'h40, 8'h02, 8'h00, 8'h01, 8'h42, 8'h00, 8'h01, 2'h1},
		'{OP_EXCL_PAIR,      8'hAA, 8'hAA, 8'h00, 8'h08, 8'h00, 8'h00, 8'h02, 2'h1},
		'{OP_MASK_SET,       8'h01, 8'h80, 8'h00, 8'h00, 8'h81, 8'h00, 8'h04, 2'h1},
		'{OP_MASK_CLEAR,     8'hFF, 8'h0F, 8'h00, 8'h00, 8'hF0, 8'h00, 8'h04, 2'h1},
		'{5'h1F,             8'h12, 8'h34, 8'h00, 8'h21, 8'h12, 8'h00, 8'h21, 2'h1}
	};

	// ****************************************
	// instances and clock
	// ****************************************
	bal_core #(.IO_DEPTH(32)) u_dut (
		.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.io_event(io_event), .busy(busy)
	);

	bal_evt_model u_evt (.sys_clk(sys_clk), .rstn(rstn), .fire(evt_fire), .io_event(io_event));

	// 200 MHz core clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		apb(1'b1, a, v, rd, er);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000, rd, er);
		chk(rd, exp);
	endtask

	// start an operation and count the cycles busy stays high
	task automatic run_op(input logic [4:0] op, output int n);
		wr(OFS_CMD, {27'h0000000, op});
		n = 0;
		@(negedge sys_clk);
		while (busy === 1'b1 && n < 8) begin
			n++;
			@(negedge sys_clk);
		end
		if (n >= 8) begin
			err_count++;
			report_and_stop();
		end
	endtask

	task automatic fire_evt();
		@(posedge sys_clk);
		evt_fire <= 1'b1;
		@(posedge sys_clk);
		evt_fire <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int n;
		err_count = 0;
		samples_checked = 0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		evt_fire = 1'b0;
		repeat (20) @(posedge sys_clk);
		chk({30'h00000000, pready, busy}, 32'h00000000);
		rstn <= 1'b1;
		// reset values
		rdchk(OFS_DEST, 32'h00000000);
		rdchk(OFS_FLAGS, 32'h00000000);
		rdchk(OFS_STATUS, 32'h00000000);
		// table of operations
		for (int i = 0; i < 16; i++) begin
			wr(OFS_DEST, {24'h000000, rows[i].d});
			wr(OFS_SRC, {24'h000000, rows[i].s});
			wr(OFS_HIGH, {24'h000000, rows[i].hi});
			wr(OFS_FLAGS, {24'h000000, rows[i].fin});
			run_op(rows[i].op, n);
			chk(n, {30'h00000000, rows[i].cyc});
			rdchk(OFS_DEST, {24'h000000, rows[i].ed});
			rdchk(OFS_HIGH, {24'h000000, rows[i].eh});
			rdchk(OFS_FLAGS, {24'h000000, rows[i].ef});
		end
		// flags clear on one, keep on zero
		wr(OFS_IO_SEL, 32'h0000000E);
		fire_evt();
		rdchk(OFS_IO_DATA, 32'h000000C0);
		wr(OFS_IO_DATA, 32'h00000040);
		rdchk(OFS_IO_DATA, 32'h00000080);
		wr(OFS_IO_DATA, 32'h00000000);
		rdchk(OFS_IO_DATA, 32'h00000080);
		// bit ops rewrite the whole register
		fire_evt();
		run_op(OP_IO_BIT_SET, n);
		rdchk(OFS_IO_DATA, 32'h00000001);
		fire_evt();
		wr(OFS_IO_SEL, 32'h0000070E);
		run_op(OP_IO_BIT_CLEAR, n);
		rdchk(OFS_IO_DATA, 32'h00000081);
		// io address range edge and beyond it
		wr(OFS_IO_SEL, 32'h0000031F);
		run_op(OP_IO_BIT_SET, n);
		rdchk(OFS_IO_DATA, 32'h00000008);
		rdchk(OFS_STATUS, 32'h00000000);
		wr(OFS_IO_SEL, 32'h00000320);
		run_op(OP_IO_BIT_SET, n);
		rdchk(OFS_STATUS, 32'h00000002);
		rdchk(OFS_IO_DATA, 32'h00000000);
		wr(OFS_STATUS, 32'h00000002);
		rdchk(OFS_STATUS, 32'h00000000);
		// unmapped and unaligned addresses
		apb(1'b0, 12'h020, 32'h00000000, rd, er);
		chk({er, rd[30:0]}, 32'h80000000);
		apb(1'b1, 12'h006, 32'h000000FF, rd, er);
		chk({31'h00000000, er}, 32'h00000001);
		report_and_stop();
	end
endmodule
